// >>> design/ufb_baud_gen.sv
`timescale 1ns/10ps
`include "ufb_map.svh"
module ufb_baud_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control and tick
  ufb_baud_if.gen bif
);
  import ufb_pkg::*;

  logic [5:0] pre_reg, pre_next;
  logic [15:0] tmr_reg, tmr_next;
  logic tick_reg, tick_next;
  logic [5:0] div;

  always_comb begin
    case (bif.sel)
      2'h0: div = `UFB_DIV_SEL0;
      2'h1: div = `UFB_DIV_SEL1;
      2'h2: div = `UFB_DIV_SEL2;
      default: div = `UFB_DIV_SEL3;
    endcase
    pre_next = pre_reg;
    tmr_next = tmr_reg;
    tick_next = 1'b0;
    if (!bif.en || bif.restart) begin
      pre_next = 6'h00;
      tmr_next = bif.reload;
    end else if (pre_reg == div - 6'h01) begin
      pre_next = 6'h00;
      if (tmr_reg == `UFB_TMR_MAX) begin
        tmr_next = bif.reload;
        tick_next = 1'b1;
      end else begin
        tmr_next = tmr_reg + 16'h0001;
      end
    end else begin
      pre_next = pre_reg + 6'h01;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      pre_reg <= 6'h00;
      tmr_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      tmr_reg <= tmr_next;
      tick_reg <= tick_next;
    end
  end

  assign bif.tick = tick_reg;
endmodule

// >>> design/ufb_baud_if.sv
`timescale 1ns/10ps
interface ufb_baud_if;
  logic en;
  logic [1:0] sel;
  logic [15:0] reload;
  logic restart;
  logic tick;
  modport ctrl (output en, output sel, output reload, output restart,
                input tick);
  modport gen (input en, input sel, input reload, input restart,
               output tick);
endinterface

// >>> design/ufb_map.svh
`ifndef UFB_MAP_SVH
`define UFB_MAP_SVH

// Register indexes; byte address is four times the index
`define UFB_IDX_CTRL 8'hd2
`define UFB_IDX_DATA 8'hd3
`define UFB_IDX_FMT 8'he5
`define UFB_IDX_BCTL 8'hac
`define UFB_IDX_RLH 8'hb5
`define UFB_IDX_RLL 8'hb4

// serial_port_control_flags fields
`define UFB_CTRL_OVR 7
`define UFB_CTRL_PARITY_ERROR_FLAG 6
`define UFB_CTRL_REN 4
`define UFB_CTRL_TBX 3
`define UFB_CTRL_RBX 2
`define UFB_CTRL_TI 1
`define UFB_CTRL_RI 0

// frame_format_config fields
`define UFB_FMT_MCE 7
`define UFB_FMT_PT_LO 5
`define UFB_FMT_PE 4
`define UFB_FMT_LEN_LO 2
`define UFB_FMT_XBE 1
`define UFB_FMT_SBL 0
`define UFB_FMT_RESET 8'h0c

// baud_generator_control fields
`define UFB_BCTL_BAUD_GENERATOR_ENABLE 6
`define UFB_BCTL_BPS_LO 0

// Prescaler divisors per select code
`define UFB_DIV_SEL0 6'h0c
`define UFB_DIV_SEL1 6'h04
`define UFB_DIV_SEL2 6'h30
`define UFB_DIV_SEL3 6'h01

// Timer limits
`define UFB_TMR_MAX 16'hffff

// Bit lengths counted in half-bit ticks
`define UFB_HALF_BIT 3'h1
`define UFB_FULL_BIT 3'h2
`define UFB_STOP_1P5 3'h3
`define UFB_STOP_2 3'h4

`endif

// >>> design/ufb_pkg.sv
package ufb_pkg;

  typedef enum logic [2:0] {
    UFB_ST_IDLE = 3'b000,
    UFB_ST_START = 3'b001,
    UFB_ST_DATA = 3'b010,
    UFB_ST_XBIT = 3'b011,
    UFB_ST_STOP = 3'b100
  } ufb_frame_state_type;

  typedef enum logic [1:0] {
    UFB_PAR_ODD = 2'b00,
    UFB_PAR_EVEN = 2'b01,
    UFB_PAR_MARK = 2'b10,
    UFB_PAR_SPACE = 2'b11
  } ufb_parity_type;

endpackage

// >>> design/ufb_top.sv
`timescale 1ns/10ps
`include "ufb_map.svh"
// Notes on behaviour
// - Dedicated 16-bit timer with 1/4/12/48 prescaler
// - Generator disabled keeps port fully inactive
// - Timer counts ticks, reloads on wrap
// - Reload is high byte joined low byte
// - Transmit to clock/2, receive to clock/8
// - Start low, data LSB first, extra, stop
// - Five to eight data bits per frame
// - Parity generated and checked, four types
// - Stop one, or two / 1.5 long
// - Parity excludes the software extra bit
// - Data write starts transmit, extra set first
// - Transmit flag set at stop-bit start
// - Receive only while enabled, on start edge
// - Store frame if space and filter passes
// - Full buffer drops new frame, keeps old
// - Receive flag set when frame is stored
// - Data read low bits, extra field stop/extra
// - Receive queue holds three bytes
// - Filtered with extra bit: only extra one
// - Sticky overrun flag on dropped character
// - Receive flag follows queue; empty read repeats
// - Rate is clock/(65536-reload)/2/prescaler
module ufb_top #(
  parameter int RX_DEPTH = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Serial lines
  input wire logic rx_in,
  output logic tx_out
);
  import ufb_pkg::*;

  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;

  ufb_baud_if tx_bif ();
  ufb_baud_if rx_bif ();

  // Bus and software registers
  logic ack_reg, ack_next;
  logic wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic pop_ok_reg, pop_ok_next;
  logic ovr_reg, ovr_next, parity_error_flag_reg, parity_error_flag_next;
  logic ren_reg, ren_next, tbx_reg, tbx_next, ti_reg, ti_next;
  logic [7:0] fmt_reg, fmt_next;
  logic baud_generator_enable_reg, baud_generator_enable_next;
  logic [1:0] bps_reg, bps_next;
  logic [7:0] rlh_reg, rlh_next, rll_reg, rll_next;
  // Transmit
  ufb_frame_state_type tx_st_reg, tx_st_next;
  logic [2:0] tx_left_reg, tx_left_next, tx_idx_reg, tx_idx_next;
  logic [7:0] tx_sh_reg, tx_sh_next;
  logic tx_xb_reg, tx_xb_next, tx_line_reg, tx_line_next;
  logic pend_reg, pend_next, pend_xb_reg, pend_xb_next;
  logic [7:0] pend_dat_reg, pend_dat_next;
  // Receive
  logic rx_s1_reg, rx_s2_reg, rx_prev_reg;
  ufb_frame_state_type rx_st_reg, rx_st_next;
  logic [2:0] rx_left_reg, rx_left_next, rx_idx_reg, rx_idx_next;
  logic [7:0] rx_sh_reg, rx_sh_next;
  logic rx_xb_reg, rx_xb_next, rst_reg, rst_next;
  logic [8:0] fifo_reg [RX_DEPTH];
  logic [8:0] fifo_next [RX_DEPTH];
  logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [8:0] last_reg, last_next;

  // Shared decode
  logic wr, pop, tx_load, ti_set, ovr_set, parity_error_flag_set;
  logic [7:0] idx, rmux;
  logic [8:0] view;
  logic address_filter_enable, pe, extra_bit_enable, sbl, has_x, soft_x, rx_tick;
  logic [1:0] dlen, ptype;
  logic [2:0] last_bit;

  function automatic logic par_bit(input logic [7:0] d,
                                   input logic [1:0] len,
                                   input logic [1:0] pt);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - len);
    case (pt)
      UFB_PAR_ODD: par_bit = ~^(d & m);
      UFB_PAR_EVEN: par_bit = ^(d & m);
      UFB_PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction

  assign address_filter_enable = fmt_reg[`UFB_FMT_MCE];
  assign pe = fmt_reg[`UFB_FMT_PE];
  assign extra_bit_enable = fmt_reg[`UFB_FMT_XBE];
  assign sbl = fmt_reg[`UFB_FMT_SBL];
  assign dlen = fmt_reg[`UFB_FMT_LEN_LO +: 2];
  assign ptype = fmt_reg[`UFB_FMT_PT_LO +: 2];
  assign has_x = pe | extra_bit_enable;
  assign soft_x = extra_bit_enable & ~pe;
  assign last_bit = {1'b0, dlen} + 3'h4;
  assign idx = avs_address[9:2];
  assign view = (cnt_reg != '0) ? fifo_reg[rp_reg] : last_reg;

  // Both generators share the software settings
  assign tx_bif.en = baud_generator_enable_reg;
  assign tx_bif.sel = bps_reg;
  assign tx_bif.reload = {rlh_reg, rll_reg};
  assign tx_bif.restart = 1'b0;
  assign rx_bif.en = baud_generator_enable_reg;
  assign rx_bif.sel = bps_reg;
  assign rx_bif.reload = {rlh_reg, rll_reg};
  assign rx_bif.restart = rst_reg;
  // Stale tick from before a restart would sample too early
  assign rx_tick = rx_bif.tick & ~rst_reg;

  ufb_baud_gen u_tx_gen (
    .core_clk(core_clk),
    .reset(reset),
    .bif(tx_bif)
  );

  ufb_baud_gen u_rx_gen (
    .core_clk(core_clk),
    .reset(reset),
    .bif(rx_bif)
  );

  // Bus slave: answer one cycle after the request is seen
  always_comb begin
    case (idx)
      `UFB_IDX_CTRL: rmux = {ovr_reg, parity_error_flag_reg, 1'b0, ren_reg, tbx_reg,
                             view[8], ti_reg, cnt_reg != '0};
      `UFB_IDX_DATA: rmux = view[7:0];
      `UFB_IDX_FMT: rmux = fmt_reg;
      `UFB_IDX_BCTL: rmux = {1'b0, baud_generator_enable_reg, 4'h0, bps_reg};
      `UFB_IDX_RLH: rmux = rlh_reg;
      `UFB_IDX_RLL: rmux = rll_reg;
      default: rmux = 8'h00;
    endcase
    ack_next = (avs_read | avs_write) & ~ack_reg;
    wait_next = ~ack_next;
    rdata_next = rdata_reg;
    pop_ok_next = pop_ok_reg;
    if (ack_next) begin
      rdata_next = {24'h0000_00, rmux};
      pop_ok_next = cnt_reg != '0;
    end
    wr = avs_write & ack_reg & avs_byteenable[0];
    pop = avs_read & ack_reg & (idx == `UFB_IDX_DATA) & pop_ok_reg;
    tx_load = wr & (idx == `UFB_IDX_DATA);
    ovr_next = ovr_reg;
    parity_error_flag_next = parity_error_flag_reg;
    ren_next = ren_reg;
    tbx_next = tbx_reg;
    ti_next = ti_reg;
    fmt_next = fmt_reg;
    baud_generator_enable_next = baud_generator_enable_reg;
    bps_next = bps_reg;
    rlh_next = rlh_reg;
    rll_next = rll_reg;
    if (wr) begin
      case (idx)
        `UFB_IDX_CTRL: begin
          ovr_next = avs_writedata[`UFB_CTRL_OVR];
          parity_error_flag_next = avs_writedata[`UFB_CTRL_PARITY_ERROR_FLAG];
          ren_next = avs_writedata[`UFB_CTRL_REN];
          tbx_next = avs_writedata[`UFB_CTRL_TBX];
          ti_next = avs_writedata[`UFB_CTRL_TI];
        end
        `UFB_IDX_FMT: fmt_next = avs_writedata[7:0];
        `UFB_IDX_BCTL: begin
          baud_generator_enable_next = avs_writedata[`UFB_BCTL_BAUD_GENERATOR_ENABLE];
          bps_next = avs_writedata[`UFB_BCTL_BPS_LO +: 2];
        end
        `UFB_IDX_RLH: rlh_next = avs_writedata[7:0];
        `UFB_IDX_RLL: rll_next = avs_writedata[7:0];
        default: ;
      endcase
    end
    // Hardware set beats a same-cycle software clear
    if (ovr_set) ovr_next = 1'b1;
    if (parity_error_flag_set) parity_error_flag_next = 1'b1;
    if (ti_set) ti_next = 1'b1;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
      wait_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      pop_ok_reg <= 1'b0;
      ovr_reg <= 1'b0;
      parity_error_flag_reg <= 1'b0;
      ren_reg <= 1'b0;
      tbx_reg <= 1'b0;
      ti_reg <= 1'b0;
      fmt_reg <= `UFB_FMT_RESET;
      baud_generator_enable_reg <= 1'b0;
      bps_reg <= 2'h0;
      rlh_reg <= 8'h00;
      rll_reg <= 8'h00;
    end else begin
      ack_reg <= ack_next;
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
      pop_ok_reg <= pop_ok_next;
      ovr_reg <= ovr_next;
      parity_error_flag_reg <= parity_error_flag_next;
      ren_reg <= ren_next;
      tbx_reg <= tbx_next;
      ti_reg <= ti_next;
      fmt_reg <= fmt_next;
      baud_generator_enable_reg <= baud_generator_enable_next;
      bps_reg <= bps_next;
      rlh_reg <= rlh_next;
      rll_reg <= rll_next;
    end
  end

  // Transmitter, paced in half-bit ticks
  always_comb begin
    tx_st_next = tx_st_reg;
    tx_left_next = tx_left_reg;
    tx_idx_next = tx_idx_reg;
    tx_sh_next = tx_sh_reg;
    tx_xb_next = tx_xb_reg;
    tx_line_next = tx_line_reg;
    pend_next = pend_reg;
    pend_xb_next = pend_xb_reg;
    pend_dat_next = pend_dat_reg;
    ti_set = 1'b0;
    if (!baud_generator_enable_reg) begin
      tx_st_next = UFB_ST_IDLE;
      tx_line_next = 1'b1;
    end else if (tx_bif.tick) begin
      case (tx_st_reg)
        UFB_ST_IDLE: if (pend_reg) begin
          tx_st_next = UFB_ST_START;
          tx_line_next = 1'b0;
          tx_left_next = `UFB_FULL_BIT;
          tx_sh_next = pend_dat_reg;
          tx_idx_next = 3'h0;
          tx_xb_next = pe ? par_bit(pend_dat_reg, dlen, ptype)
                          : pend_xb_reg;
          pend_next = 1'b0;
        end
        UFB_ST_START, UFB_ST_DATA, UFB_ST_XBIT, UFB_ST_STOP: begin
          if (tx_left_reg != `UFB_HALF_BIT) begin
            tx_left_next = tx_left_reg - 3'h1;
          end else begin
            tx_left_next = `UFB_FULL_BIT;
            case (tx_st_reg)
              UFB_ST_START: begin
                tx_st_next = UFB_ST_DATA;
                tx_line_next = tx_sh_reg[0];
              end
              UFB_ST_DATA: if (tx_idx_reg != last_bit) begin
                tx_idx_next = tx_idx_reg + 3'h1;
                tx_sh_next = tx_sh_reg >> 1;
                tx_line_next = tx_sh_reg[1];
              end else if (has_x) begin
                tx_st_next = UFB_ST_XBIT;
                tx_line_next = tx_xb_reg;
              end else begin
                tx_st_next = UFB_ST_STOP;
              end
              UFB_ST_XBIT: tx_st_next = UFB_ST_STOP;
              default: tx_st_next = UFB_ST_IDLE;
            endcase
            if (tx_st_next == UFB_ST_STOP) begin
              tx_line_next = 1'b1;
              ti_set = 1'b1;
              tx_left_next = !sbl ? `UFB_FULL_BIT
                : (dlen == 2'h0) ? `UFB_STOP_1P5 : `UFB_STOP_2;
            end
          end
        end
        default: tx_st_next = UFB_ST_IDLE;
      endcase
    end
    // A write while one is pending replaces the pending byte
    if (tx_load) begin
      pend_next = 1'b1;
      pend_dat_next = avs_writedata[7:0];
      pend_xb_next = tbx_reg;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tx_st_reg <= UFB_ST_IDLE;
      tx_left_reg <= 3'h0;
      tx_idx_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      tx_xb_reg <= 1'b0;
      tx_line_reg <= 1'b1;
      pend_reg <= 1'b0;
      pend_xb_reg <= 1'b0;
      pend_dat_reg <= 8'h00;
    end else begin
      tx_st_reg <= tx_st_next;
      tx_left_reg <= tx_left_next;
      tx_idx_reg <= tx_idx_next;
      tx_sh_reg <= tx_sh_next;
      tx_xb_reg <= tx_xb_next;
      tx_line_reg <= tx_line_next;
      pend_reg <= pend_next;
      pend_xb_reg <= pend_xb_next;
      pend_dat_reg <= pend_dat_next;
    end
  end

  // Receiver and queue
  always_comb begin
    logic keep, stop, push;
    keep = 1'b0;
    stop = rx_s2_reg;
    push = 1'b0;
    rx_st_next = rx_st_reg;
    rx_left_next = rx_left_reg;
    rx_idx_next = rx_idx_reg;
    rx_sh_next = rx_sh_reg;
    rx_xb_next = rx_xb_reg;
    rst_next = 1'b0;
    ovr_set = 1'b0;
    parity_error_flag_set = 1'b0;
    fifo_next = fifo_reg;
    wp_next = wp_reg;
    rp_next = rp_reg;
    cnt_next = cnt_reg;
    last_next = last_reg;
    if (!ren_reg || !baud_generator_enable_reg) begin
      rx_st_next = UFB_ST_IDLE;
    end else if (rx_st_reg == UFB_ST_IDLE) begin
      if (rx_prev_reg && !rx_s2_reg) begin
        rx_st_next = UFB_ST_START;
        rst_next = 1'b1;
        rx_left_next = `UFB_HALF_BIT;
        rx_idx_next = 3'h0;
        rx_sh_next = 8'h00;
        rx_xb_next = 1'b0;
      end
    end else if (rx_tick) begin
      if (rx_left_reg != `UFB_HALF_BIT) begin
        rx_left_next = rx_left_reg - 3'h1;
      end else begin
        rx_left_next = `UFB_FULL_BIT;
        case (rx_st_reg)
          // A glitch that is high mid start bit is not a frame
          UFB_ST_START: rx_st_next = rx_s2_reg ? UFB_ST_IDLE : UFB_ST_DATA;
          UFB_ST_DATA: begin
            rx_sh_next[rx_idx_reg] = rx_s2_reg;
            rx_idx_next = rx_idx_reg + 3'h1;
            if (rx_idx_reg == last_bit) begin
              rx_st_next = has_x ? UFB_ST_XBIT : UFB_ST_STOP;
            end
          end
          UFB_ST_XBIT: begin
            rx_xb_next = rx_s2_reg;
            rx_st_next = UFB_ST_STOP;
          end
          UFB_ST_STOP: begin
            rx_st_next = UFB_ST_IDLE;
            keep = !address_filter_enable || (soft_x ? rx_xb_reg : stop);
            if (keep && pe &&
                rx_xb_reg != par_bit(rx_sh_reg, dlen, ptype)) begin
              parity_error_flag_set = 1'b1;
            end
            if (keep && cnt_reg != RX_DEPTH[CW-1:0]) begin
              push = 1'b1;
            end else if (keep) begin
              ovr_set = 1'b1;
            end
          end
          default: rx_st_next = UFB_ST_IDLE;
        endcase
      end
    end
    if (push) begin
      fifo_next[wp_reg] = {soft_x ? rx_xb_reg : stop, rx_sh_reg};
      wp_next = (wp_reg == PW'(RX_DEPTH - 1)) ? '0 : wp_reg + 1'b1;
    end
    if (pop) begin
      last_next = fifo_reg[rp_reg];
      rp_next = (rp_reg == PW'(RX_DEPTH - 1)) ? '0 : rp_reg + 1'b1;
    end
    cnt_next = cnt_reg + CW'(push) - CW'(pop);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
      rx_st_reg <= UFB_ST_IDLE;
      rx_left_reg <= 3'h0;
      rx_idx_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_xb_reg <= 1'b0;
      rst_reg <= 1'b0;
      for (int i = 0; i < RX_DEPTH; i++) fifo_reg[i] <= 9'h000;
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      last_reg <= 9'h000;
    end else begin
      rx_s1_reg <= rx_in;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
      rx_st_reg <= rx_st_next;
      rx_left_reg <= rx_left_next;
      rx_idx_reg <= rx_idx_next;
      rx_sh_reg <= rx_sh_next;
      rx_xb_reg <= rx_xb_next;
      rst_reg <= rst_next;
      fifo_reg <= fifo_next;
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      last_reg <= last_next;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign tx_out = tx_line_reg;
endmodule

// >>> test/ufb_remote_port.sv
`timescale 1ns/10ps
module ufb_remote_port (
  // Clock
  input wire logic core_clk,
  // Line timing and capture length
  input wire logic [15:0] half_cyc,
  input wire logic [3:0] cap_n,
  // Serial lines, named from the block's side
  input wire logic tx_out,
  output logic rx_in,
  // Captured frame
  output logic [10:0] got_bits,
  output logic [7:0] got_count
);
  initial begin
    rx_in = 1'b1;
    got_bits = 11'h000;
    got_count = 8'h00;
  end
  // Caller includes stop bits, so the line is left high
  task automatic send(input logic [10:0] bits, input int n);
    rx_in <= 1'b0;
    repeat (2 * half_cyc) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      rx_in <= bits[i];
      repeat (2 * half_cyc) @(posedge core_clk);
    end
  endtask
  // Sampled mid-bit, so the edge race never matters
  always begin
    @(negedge tx_out);
    got_bits = 11'h000;
    repeat (half_cyc) @(posedge core_clk);
    for (int i = 0; i < cap_n; i++) begin
      repeat (2 * half_cyc) @(posedge core_clk);
      got_bits[i] = tx_out;
    end
    got_count = got_count + 8'h01;
  end
endmodule

// >>> test/ufb_top_properties.sv
`timescale 1ns/10ps
`include "ufb_map.svh"
module ufb_top_checker #(
  parameter int RX_DEPTH = 3
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register bus
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Serial lines
  input wire logic rx_in,
  input wire logic tx_out
);
  logic en_reg, en_next, en_old_reg, mapped;
  // Shadow of the generator enable, from accepted writes only
  always_comb begin
    en_next = en_reg;
    if (avs_write && !avs_waitrequest && avs_byteenable[0] &&
        avs_address[9:2] == `UFB_IDX_BCTL) begin
      en_next = avs_writedata[`UFB_BCTL_BAUD_GENERATOR_ENABLE];
    end
  end
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      en_reg <= 1'b0;
      en_old_reg <= 1'b0;
    end else begin
      en_reg <= en_next;
      en_old_reg <= en_reg;
    end
  end
  assign mapped = avs_address[9:2] inside {`UFB_IDX_CTRL, `UFB_IDX_DATA,
    `UFB_IDX_FMT, `UFB_IDX_BCTL, `UFB_IDX_RLH, `UFB_IDX_RLL};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_wait_after_take: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  a_answer_needs_request: assert property (!avs_waitrequest |->
    $past(avs_read || avs_write)) else $error("answer without request");
  // Extra cycle of slack for the registered line after disable
  a_idle_when_off: assert property (!en_reg && !en_old_reg |-> tx_out)
    else $error("line active while generator off");
  a_readdata_upper_zero: assert property (!avs_waitrequest |->
    avs_readdata[31:8] == 24'h00_0000) else $error("upper bits set");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest &&
    !mapped |-> avs_readdata == 32'h0000_0000) else $error("unmapped data");
  a_bit_min_width: assert property ($changed(tx_out) |=> $stable(tx_out))
    else $error("serial bit shorter than two cycles");
  a_readdata_holds: assert property (avs_waitrequest |-> $stable(avs_readdata))
    else $error("read data moved between answers");
endmodule
bind ufb_top ufb_top_checker #(.RX_DEPTH(RX_DEPTH)) ufb_top_checker_inst (
  .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .rx_in(rx_in), .tx_out(tx_out));

// >>> test/ufb_top_test.sv
`timescale 1ns/10ps
`include "ufb_map.svh"
module ufb_top_test;
  import ufb_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, rx_in, tx_out;
  logic [15:0] half_cyc = 16'h0008;
  logic [3:0] cap_n = 4'h9;
  logic [10:0] got_bits;
  logic [7:0] got_count, seen_count;
  int miscompares = 0;
  int samples_checked = 0;
  logic [1:0] ps_sel [5] = '{2'h3, 2'h1, 2'h0, 2'h2, 2'h3};
  logic [7:0] ps_low [5] = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'hf8};
  logic [15:0] ps_half [5] = '{16'h0001, 16'h0008, 16'h000c, 16'h0030,
    16'h0008};
  // Long stop on the 5-bit and one 8-bit frame
  logic [7:0] tx_fmt [10] = '{8'h01, 8'h04, 8'h08, 8'h0d, 8'h1c, 8'h3c,
    8'h5c, 8'h7c, 8'h0e, 8'h1e};
  logic [7:0] tx_dat [10] = '{8'h35, 8'h2a, 8'h55, 8'ha5, 8'h5b, 8'h5b,
    8'h5b, 8'h5b, 8'h33, 8'h5b};
  always #2 core_clk = ~core_clk;
  ufb_top #(.RX_DEPTH(3)) ufb_top_inst (.core_clk(core_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_in(rx_in), .tx_out(tx_out));
  ufb_remote_port ufb_remote_port_inst (.core_clk(core_clk),
    .half_cyc(half_cyc), .cap_n(cap_n), .tx_out(tx_out), .rx_in(rx_in),
    .got_bits(got_bits), .got_count(got_count));
  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, want);
    end
  endtask
  // Request held until waitrequest is seen low; one idle edge after
  task automatic bus(input logic is_wr, input logic [7:0] idx,
                     input logic [7:0] d);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, d};
    avs_write <= is_wr;
    avs_read <= !is_wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task automatic rc(input logic [7:0] idx, input logic [7:0] want);
    bus(1'b0, idx, 8'h00);
    check(rd, {24'h00_0000, want});
  endtask
  task automatic await_frame();
    repeat (4000) if (got_count === seen_count) @(posedge core_clk);
    // A wait that runs out is a mismatch, not a silent pass
    check(32'(got_count), 32'(seen_count + 8'h01));
  endtask
  // Bits after the start bit as the line should carry them
  function automatic logic [10:0] frame(input logic [7:0] f,
      input logic x, input logic [7:0] d, output logic [3:0] n);
    logic [3:0] nd;
    logic [7:0] dm;
    logic ex, p;
    nd = {2'b00, f[3:2]} + 4'h5;
    dm = d & ~(8'hff << nd);
    ex = f[`UFB_FMT_PE] | f[`UFB_FMT_XBE];
    p = f[`UFB_FMT_PE] ? (f[6] ? ~f[5] : ^dm ^ ~f[5]) : x & ex;
    n = nd + {3'b000, ex} + 4'h1;
    return {3'b000, dm} | ({10'h000, p} << nd) | (11'h001 << (n - 4'h1));
  endfunction
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    close_out();
  end
  initial begin
    logic [3:0] n;
    logic [10:0] fb;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rc(`UFB_IDX_CTRL, 8'h00);
    rc(`UFB_IDX_FMT, `UFB_FMT_RESET);
    rc(`UFB_IDX_BCTL, 8'h00);
    rc(`UFB_IDX_RLH, 8'h00);
    rc(`UFB_IDX_RLL, 8'h00);
    rc(8'h00, 8'h00);
    avs_byteenable <= 4'he;
    wr(`UFB_IDX_FMT, 8'hff);
    avs_byteenable <= 4'hf;
    rc(`UFB_IDX_FMT, `UFB_FMT_RESET);
    // Generator off: pending byte waits, incoming frame ignored
    wr(`UFB_IDX_CTRL, 8'h10);
    wr(`UFB_IDX_DATA, 8'h77);
    seen_count = got_count;
    ufb_remote_port_inst.send(11'h1a5, 9);
    rc(`UFB_IDX_CTRL, 8'h10);
    check({24'h00_0000, got_count}, {24'h00_0000, seen_count});
    wr(`UFB_IDX_CTRL, 8'h00);
    for (int k = 0; k < 5; k++) begin
      half_cyc <= ps_half[k];
      wr(`UFB_IDX_RLH, 8'hff);
      wr(`UFB_IDX_RLL, ps_low[k]);
      seen_count = got_count;
      wr(`UFB_IDX_BCTL, {6'h10, ps_sel[k]});
      if (k > 0) wr(`UFB_IDX_DATA, 8'hc3 ^ k[7:0]);
      await_frame();
      fb = {3'b001, (k > 0) ? (8'hc3 ^ k[7:0]) : 8'h77};
      check({21'h00_0000, got_bits}, {21'h00_0000, fb});
    end
    for (int k = 0; k < 10; k++) begin
      wr(`UFB_IDX_FMT, tx_fmt[k]);
      wr(`UFB_IDX_CTRL, {4'h0, tx_fmt[k][1], 3'b000});
      fb = frame(tx_fmt[k], tx_fmt[k][1], tx_dat[k], n);
      cap_n <= n;
      seen_count = got_count;
      wr(`UFB_IDX_DATA, tx_dat[k]);
      await_frame();
      check({21'h00_0000, got_bits}, {21'h00_0000, fb});
      rc(`UFB_IDX_CTRL, {4'h0, tx_fmt[k][1], 3'b010});
    end
    wr(`UFB_IDX_FMT, 8'h0c);
    // Receive tests run at a sixteenth of the clock
    wr(`UFB_IDX_CTRL, 8'h10);
    for (int k = 1; k < 5; k++) begin
      ufb_remote_port_inst.send({3'b001, k[3:0], k[3:0]}, 9);
    end
    rc(`UFB_IDX_CTRL, 8'h95);
    for (int k = 1; k < 4; k++) begin
      rc(`UFB_IDX_DATA, {k[3:0], k[3:0]});
    end
    rc(`UFB_IDX_CTRL, 8'h94);
    rc(`UFB_IDX_DATA, 8'h33);
    wr(`UFB_IDX_CTRL, 8'h10);
    rc(`UFB_IDX_CTRL, 8'h14);
    // Address filter with extra bit: only extra bit one is kept
    wr(`UFB_IDX_FMT, 8'h8e);
    ufb_remote_port_inst.send(11'h2a1, 10);
    bus(1'b0, `UFB_IDX_CTRL, 8'h00);
    check(rd & 32'h0000_00fb, 32'h0000_0010);
    ufb_remote_port_inst.send(11'h3a2, 10);
    rc(`UFB_IDX_CTRL, 8'h15);
    rc(`UFB_IDX_DATA, 8'ha2);
    // Even parity: wrong bit first, then a good one
    wr(`UFB_IDX_FMT, 8'h3c);
    ufb_remote_port_inst.send(11'h25b, 10);
    bus(1'b0, `UFB_IDX_CTRL, 8'h00);
    check(rd & 32'h0000_00fb, 32'h0000_0051);
    rc(`UFB_IDX_DATA, 8'h5b);
    wr(`UFB_IDX_CTRL, 8'h10);
    ufb_remote_port_inst.send(11'h35b, 10);
    bus(1'b0, `UFB_IDX_CTRL, 8'h00);
    check(rd & 32'h0000_00fb, 32'h0000_0011);
    rc(`UFB_IDX_DATA, 8'h5b);
    wr(`UFB_IDX_CTRL, 8'h00);
    ufb_remote_port_inst.send(11'h35b, 10);
    bus(1'b0, `UFB_IDX_CTRL, 8'h00);
    check(rd & 32'h0000_00fb, 32'h0000_0000);
    close_out();
  end
endmodule
